// [src/arb_params.svh]
// Timing counts, field widths and decode constants for the bus controller.
// Assumes one bus clock shared with the processor; counts are bus cycles.
`ifndef ARB_PARAMS_SVH
`define ARB_PARAMS_SVH

// Cycle (TS cycle = 0) in which acknowledge may first be low
`define ACK_FIRST_FAST    4'h1
`define ACK_FIRST_SLOW    4'h2
// Cycle in which our own snoop retry may first be low
`define RETRY_FIRST       4'h2
// Transfer type decode for address-only operations
`define ADDR_ONLY_MASK    5'h08
`define ADDR_ONLY_VALUE   5'h00
// Data beats acknowledged per data tenure
`define BEAT_COUNT        3'h4
`define TT_WIDTH          5
`define CNT_WIDTH         4

`endif

// [src/arb_pkg.sv]
// Types for the bus controller: pin groups and state encodings.
// Assumes arb_params.svh is on the include path.
`include "arb_params.svh"
package arb_pkg;

   // Pins driven by the processor, plus the shared retry wire level
   typedef struct packed {
      logic                     transfer_start_n;
      logic [`TT_WIDTH-1:0]     transfer_type;
      logic                     address_request_n;
      logic                     data_busy_n;
      logic                     address_retry_n;
   } from_cpu_type;

   // Pins driven by this controller
   typedef struct packed {
      logic address_grant_n;
      logic address_acknowledge_o;
      logic address_acknowledge_oe;
      logic address_retry_o;
      logic address_retry_oe;
      logic data_grant_n;
      logic transfer_acknowledge_n;
      logic data_retry_n;
   } to_cpu_type;

   typedef enum logic [2:0] {
      a_idle, a_granted, a_tenure, a_ack, a_after, a_block
   } addr_state_type;

   typedef enum logic [1:0] {
      d_idle, d_wait_busy, d_beats, d_gap
   } data_state_type;

endpackage

// [src/shared_line_driver.sv]
// Driver for a shared active-low line: low while asked, one cycle of
// driven high afterwards, then released.
// Assumes a pull-up on the wire; the enable is high while driving.
`timescale 1ns/1ps
module shared_line_driver
(
   input  wire logic clk,      // Bus clock
   input  wire logic srst,     // Synchronous reset, active high
   input  wire logic assert_in,// Hold line low next cycle
   output logic      line_o,   // Level driven onto the wire
   output logic      line_oe   // High while driving the wire
);
   logic held;
   logic next_held;
   logic next_o;
   logic next_oe;

   always_comb
   begin
      next_held = assert_in;
      next_o    = ~assert_in;
      // Released after one cycle of driven-high precharge
      next_oe   = assert_in | held;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         held    <= 1'b0;
         line_o  <= 1'b1;
         line_oe <= 1'b0;
      end
      else
      begin
         held    <= next_held;
         line_o  <= next_o;
         line_oe <= next_oe;
      end
   end
endmodule

// [src/addr_termination_data_bus_arb.sv]
// System-side controller for a split-transaction processor bus: address
// arbitration and termination, snoop retry, and data bus grant.
// Assumes the processor shares clk; its pins need no synchroniser.
//
// How it works
// - Acknowledge withheld to stretch the address phase.
// - Acknowledge never in the transfer-start cycle.
// - Slow ratios: acknowledge no earlier than third clock.
// - Fast ratios: acknowledge from the second clock.
// - Assert, precharge high one cycle, then release.
// - Acknowledge low for exactly one cycle.
// - Retry through post-acknowledge cycle reruns whole transaction.
// - Own snoop retry no earlier than second cycle.
// - Own retry held through cycle after acknowledge.
// - Post-acknowledge retry qualified, earlier ones early.
// - Never retry after first transfer acknowledge.
// - After qualified retry, only copy-back snooper requests.
// - Transfer start requests data; address-only gets none.
`timescale 1ns/1ps
`include "arb_params.svh"
module addr_termination_data_bus_arb
(
   input  wire logic                    clk,          // Bus clock
   input  wire logic                    srst,         // Sync reset, high
   input  wire arb_pkg::from_cpu_type   cpu_in,       // Processor pins
   output arb_pkg::to_cpu_type          cpu_out,      // Controller pins
   input  wire logic                    ratio_slow,   // 1:1 or 1.5:1 mode
   input  wire logic [1:0]              ack_wait,     // Extra ack waits
   input  wire logic                    snoop_retry,  // Snooper wants retry
   input  wire logic                    copyback_req, // Snooper bus request
   output logic                         copyback_gnt, // Snooper bus grant
   output logic                         tenure_done,  // Address tenure ok
   output logic                         early_retry,  // Ended, early retry
   output logic                         qual_retry    // Ended, qualified
);
   arb_pkg::addr_state_type   astate;
   arb_pkg::addr_state_type   next_astate;
   arb_pkg::data_state_type   dstate;
   arb_pkg::data_state_type   next_dstate;
   logic [`CNT_WIDTH-1:0]     cnt;
   logic [`CNT_WIDTH-1:0]     next_cnt;
   logic [`CNT_WIDTH-1:0]     cur;
   logic [`CNT_WIDTH-1:0]     target;
   logic                      ratio;
   logic                      next_ratio;
   logic                      ratio_taken;
   logic                      next_ratio_taken;
   logic                      needs_data;
   logic                      next_needs_data;
   logic                      seen_retry;
   logic                      next_seen_retry;
   logic                      own_retry;
   logic                      next_own_retry;
   logic                      retry_assert;
   logic                      ack_fire;
   logic                      ts_now;
   logic                      retry_now;
   logic                      data_pending;
   logic                      next_data_pending;
   logic                      grant_n;
   logic                      next_grant_n;
   logic                      dgrant_n;
   logic                      next_dgrant_n;
   logic                      ta_n;
   logic                      next_ta_n;
   logic [2:0]                beats;
   logic [2:0]                next_beats;
   logic                      next_copyback_gnt;
   logic                      next_done;
   logic                      next_early;
   logic                      next_qual;

   // Processor shares the bus clock, pins are used as sampled
   assign ts_now    = ~cpu_in.transfer_start_n;
   assign retry_now = ~cpu_in.address_retry_n;

   // Ratio latched once after reset
   always_comb
   begin
      next_ratio       = ratio;
      next_ratio_taken = 1'b1;
      if (!ratio_taken)
         next_ratio = ratio_slow;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         ratio       <= 1'b0;
         ratio_taken <= 1'b0;
      end
      else
      begin
         ratio       <= next_ratio;
         ratio_taken <= next_ratio_taken;
      end
   end

   // Address tenure sequencing
   always_comb
   begin
      next_astate       = astate;
      next_cnt          = cnt;
      next_needs_data   = needs_data;
      next_seen_retry   = seen_retry;
      next_grant_n      = grant_n;
      next_copyback_gnt = 1'b0;
      next_done         = 1'b0;
      next_early        = 1'b0;
      next_qual         = 1'b0;
      next_data_pending = data_pending;
      cur               = (astate == arb_pkg::a_tenure) ? cnt : '0;
      // Earliest acknowledge cycle set by the clock ratio
      target = (ratio ? `ACK_FIRST_SLOW : `ACK_FIRST_FAST)
               + {2'b00, ack_wait};
      ack_fire = 1'b0;
      case (astate)
         arb_pkg::a_idle:
         begin
            // No new address tenure while a data tenure waits
            if (!cpu_in.address_request_n && !data_pending)
            begin
               next_grant_n = 1'b0;
               next_astate  = arb_pkg::a_granted;
            end
         end
         arb_pkg::a_granted:
         begin
            if (ts_now)
            begin
               next_grant_n    = 1'b1;
               next_cnt        = cur + 4'h1;
               next_seen_retry = 1'b0;
               // Address-only types need no data bus
               next_needs_data = (cpu_in.transfer_type & `ADDR_ONLY_MASK)
                                 != `ADDR_ONLY_VALUE;
               ack_fire        = (cur + 4'h1 == target);
               next_astate     = ack_fire ? arb_pkg::a_ack
                                          : arb_pkg::a_tenure;
            end
            else if (cpu_in.address_request_n)
            begin
               next_grant_n = 1'b1;
               next_astate  = arb_pkg::a_idle;
            end
         end
         arb_pkg::a_tenure:
         begin
            // Acknowledge held off until the target cycle
            next_cnt = cur + 4'h1;
            if (retry_now)
               next_seen_retry = 1'b1;
            ack_fire = (cur + 4'h1 == target);
            if (ack_fire)
               next_astate = arb_pkg::a_ack;
         end
         arb_pkg::a_ack:
         begin
            if (retry_now)
               next_seen_retry = 1'b1;
            next_astate = arb_pkg::a_after;
         end
         arb_pkg::a_after:
         begin
            // Retry seen before is early, first seen here qualified
            if (seen_retry)
            begin
               next_early  = 1'b1;
               next_astate = arb_pkg::a_idle;
            end
            else if (retry_now)
            begin
               next_qual   = 1'b1;
               next_astate = arb_pkg::a_block;
            end
            else
            begin
               next_done         = 1'b1;
               next_data_pending = needs_data;
               next_astate       = arb_pkg::a_idle;
            end
         end
         arb_pkg::a_block:
         begin
            // Processor request ignored, only the copy-back snooper
            next_copyback_gnt = copyback_req;
            next_astate       = arb_pkg::a_idle;
         end
         default:
            next_astate = arb_pkg::a_idle;
      endcase
      // Pending ends with the data tenure; a set in the same cycle wins
      if (dstate == arb_pkg::d_gap && !next_done)
         next_data_pending = 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         astate       <= arb_pkg::a_idle;
         cnt          <= '0;
         needs_data   <= 1'b0;
         seen_retry   <= 1'b0;
         grant_n      <= 1'b1;
         copyback_gnt <= 1'b0;
         tenure_done  <= 1'b0;
         early_retry  <= 1'b0;
         qual_retry   <= 1'b0;
         data_pending <= 1'b0;
      end
      else
      begin
         astate       <= next_astate;
         cnt          <= next_cnt;
         needs_data   <= next_needs_data;
         seen_retry   <= next_seen_retry;
         grant_n      <= next_grant_n;
         copyback_gnt <= next_copyback_gnt;
         tenure_done  <= next_done;
         early_retry  <= next_early;
         qual_retry   <= next_qual;
         data_pending <= next_data_pending;
      end
   end

   // Own snoop retry: from cycle 2, held through cycle after ack
   always_comb
   begin
      retry_assert = own_retry && astate != arb_pkg::a_after;
      if (snoop_retry && ((astate == arb_pkg::a_tenure
                           && cur + 4'h1 >= `RETRY_FIRST)
                          || astate == arb_pkg::a_ack))
         retry_assert = 1'b1;
      next_own_retry = retry_assert;
   end

   always_ff @(posedge clk)
   begin
      if (srst)
         own_retry <= 1'b0;
      else
         own_retry <= next_own_retry;
   end

   // Data tenure: grant, wait for busy, acknowledge beats, gap
   always_comb
   begin
      next_dstate   = dstate;
      next_dgrant_n = 1'b1;
      next_ta_n     = 1'b1;
      next_beats    = beats;
      case (dstate)
         arb_pkg::d_idle:
         begin
            // Grant only when busy negated and tenure not retried
            if (data_pending && cpu_in.data_busy_n && !retry_now)
            begin
               next_dgrant_n = 1'b0;
               next_dstate   = arb_pkg::d_wait_busy;
            end
         end
         arb_pkg::d_wait_busy:
         begin
            if (!cpu_in.data_busy_n)
            begin
               next_ta_n   = 1'b0;
               next_beats  = `BEAT_COUNT - 3'h1;
               next_dstate = arb_pkg::d_beats;
            end
            else if (dgrant_n)
               next_dstate = arb_pkg::d_idle;
            else
               next_dgrant_n = 1'b0;
         end
         arb_pkg::d_beats:
         begin
            if (beats != 3'h0)
            begin
               next_ta_n  = 1'b0;
               next_beats = beats - 3'h1;
            end
            else
               next_dstate = arb_pkg::d_gap;
         end
         arb_pkg::d_gap:
            next_dstate = arb_pkg::d_idle;
         default:
            next_dstate = arb_pkg::d_idle;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         dstate   <= arb_pkg::d_idle;
         dgrant_n <= 1'b1;
         ta_n     <= 1'b1;
         beats    <= 3'h0;
      end
      else
      begin
         dstate   <= next_dstate;
         dgrant_n <= next_dgrant_n;
         ta_n     <= next_ta_n;
         beats    <= next_beats;
      end
   end

   // Shared lines: low, precharge high, release
   shared_line_driver ack_drv
   (
      .clk       (clk),
      .srst      (srst),
      .assert_in (ack_fire),
      .line_o    (cpu_out.address_acknowledge_o),
      .line_oe   (cpu_out.address_acknowledge_oe)
   );

   shared_line_driver retry_drv
   (
      .clk       (clk),
      .srst      (srst),
      .assert_in (retry_assert),
      .line_o    (cpu_out.address_retry_o),
      .line_oe   (cpu_out.address_retry_oe)
   );

   assign cpu_out.address_grant_n        = grant_n;
   assign cpu_out.data_grant_n           = dgrant_n;
   assign cpu_out.transfer_acknowledge_n = ta_n;
   assign cpu_out.data_retry_n           = 1'b1;
endmodule

// [bench/arb_properties.sv]
// Pin-level checks of the bus controller, bound to its top module.
// Assumes one clock domain and a synchronous reset.
`timescale 1ns/1ps
module arb_properties
(
   input wire logic                  clk,         // Bus clock
   input wire logic                  srst,        // Sync reset
   input wire arb_pkg::from_cpu_type cpu_in,      // Processor pins
   input wire arb_pkg::to_cpu_type   cpu_out,     // Controller pins
   input wire logic                  ratio_slow,  // Slow ratio mode
   input wire logic [1:0]            ack_wait,    // Extra ack waits
   input wire logic                  tenure_done, // Tenure ok
   input wire logic                  early_retry, // Early retry
   input wire logic                  qual_retry   // Qualified retry
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);
   wire ack_lo = cpu_out.address_acknowledge_oe
                 & ~cpu_out.address_acknowledge_o;
   wire rty_lo = cpu_out.address_retry_oe & ~cpu_out.address_retry_o;
   wire ts_go  = ~cpu_in.transfer_start_n & ~cpu_out.address_grant_n;
   wire rty_on = ~cpu_in.address_retry_n;
   wire ta_n   = cpu_out.transfer_acknowledge_n;
   sequence s_ack_end;
      cpu_out.address_acknowledge_oe && cpu_out.address_acknowledge_o
      ##1 !cpu_out.address_acknowledge_oe;
   endsequence
   sequence s_rty_end;
      cpu_out.address_retry_oe && cpu_out.address_retry_o
      ##1 !cpu_out.address_retry_oe;
   endsequence
   property p_ack_fast;
      ts_go && !ratio_slow && ack_wait == 2'h0 |=> ack_lo;
   endproperty
   a_ack_fast: assert property (p_ack_fast)
      else $error("fast acknowledge not in second cycle");
   property p_ack_slow;
      ts_go && ratio_slow && ack_wait == 2'h0 |=> !ack_lo ##1 ack_lo;
   endproperty
   a_ack_slow: assert property (p_ack_slow)
      else $error("slow acknowledge not in third cycle");
   property p_ack_once;
      ack_lo |=> s_ack_end;
   endproperty
   a_ack_once: assert property (p_ack_once)
      else $error("acknowledge pulse shape wrong");
   property p_rty_late;
      ts_go |=> !rty_lo;
   endproperty
   a_rty_late: assert property (p_rty_late)
      else $error("own retry too early");
   property p_rty_hold;
      rty_lo && ack_lo |=> rty_lo ##1 s_rty_end;
   endproperty
   a_rty_hold: assert property (p_rty_hold)
      else $error("own retry not held past acknowledge");
   property p_done;
      ack_lo ##1 !rty_on |=> tenure_done && !qual_retry;
   endproperty
   a_done: assert property (p_done)
      else $error("clean tenure not reported");
   property p_qual;
      ack_lo && !rty_on ##1 rty_on |=> qual_retry && !early_retry;
   endproperty
   a_qual: assert property (p_qual)
      else $error("qualified retry not reported");
   property p_early;
      ack_lo && rty_on |=> ##1 early_retry && !tenure_done;
   endproperty
   a_early: assert property (p_early)
      else $error("early retry not reported");
   property p_block;
      ack_lo ##1 rty_on |=> cpu_out.address_grant_n [*2];
   endproperty
   a_block: assert property (p_block)
      else $error("address grant after qualified retry");
   property p_beats;
      $fell(cpu_in.data_busy_n) |=> !ta_n [*4] ##1 ta_n;
   endproperty
   a_beats: assert property (p_beats)
      else $error("data beat count wrong");
endmodule

bind addr_termination_data_bus_arb arb_properties i_props
(
   .clk(clk), .srst(srst), .cpu_in(cpu_in), .cpu_out(cpu_out),
   .ratio_slow(ratio_slow), .ack_wait(ack_wait),
   .tenure_done(tenure_done), .early_retry(early_retry),
   .qual_retry(qual_retry)
);

// [bench/cpu_model.sv]
// Behavioural processor: one address tenure at a time, then its data.
// Assumes a pull-up on the retry wire; never retries snoops itself.
`timescale 1ns/1ps
`include "arb_params.svh"
module cpu_model
(
   input  wire logic                clk,     // Bus clock
   input  wire logic                srst,    // Sync reset
   input  wire logic                go,      // Start one transaction
   input  wire logic [4:0]          tt_in,   // Its transfer type
   input  wire arb_pkg::to_cpu_type cpu_out, // Controller pins
   output arb_pkg::from_cpu_type    cpu_in   // Processor pins
);
   logic       want, ten, chk, hold_off, owe, busy_n, gap, ts_n;
   logic [4:0] tt;
   logic [2:0] beats;
   wire ack   = cpu_out.address_acknowledge_oe
                & ~cpu_out.address_acknowledge_o;
   wire rty_n = ~(cpu_out.address_retry_oe & ~cpu_out.address_retry_o);
   wire dgq   = ~cpu_out.data_grant_n & busy_n & cpu_out.data_retry_n
                & rty_n & ~gap;

   always_comb
   begin
      cpu_in.transfer_start_n  = ts_n;
      cpu_in.transfer_type     = ts_n ? ~tt : tt;
      cpu_in.address_request_n = ~(want & ~ten & ~hold_off);
      cpu_in.data_busy_n       = busy_n;
      cpu_in.address_retry_n   = rty_n;
   end

   always @(posedge clk)
   begin
      ts_n     <= 1'b1;
      hold_off <= 1'b0;
      gap      <= 1'b0;
      if (srst)
      begin
         want   <= 1'b0;
         ten    <= 1'b0;
         chk    <= 1'b0;
         owe    <= 1'b0;
         busy_n <= 1'b1;
         beats  <= 3'h0;
      end
      else
      begin
         if (go)
         begin
            want <= 1'b1;
            tt   <= tt_in;
         end
         if (want && !ten && !hold_off && !cpu_out.address_grant_n)
         begin
            ts_n <= 1'b0;
            ten  <= 1'b1;
         end
         if (ten && ack)
            chk <= 1'b1;
         if (chk)
         begin
            chk <= 1'b0;
            ten <= 1'b0;
            if (rty_n)
            begin
               want <= 1'b0;
               owe  <= (tt & `ADDR_ONLY_MASK) != `ADDR_ONLY_VALUE;
            end
            else
               hold_off <= 1'b1;
         end
         if (owe && dgq)
            busy_n <= 1'b0;
         if (!busy_n && !cpu_out.transfer_acknowledge_n)
         begin
            beats <= beats + 3'h1;
            if (beats == `BEAT_COUNT - 3'h1)
            begin
               busy_n <= 1'b1;
               owe    <= 1'b0;
               gap    <= 1'b1;
               beats  <= 3'h0;
            end
         end
      end
   end
endmodule

// [bench/testbench.sv]
// Self-checking bench: random tenures, retries and data bursts.
// Assumes the controller, cpu_model and the checker are compiled first.
`timescale 1ns/1ps
`include "arb_params.svh"
module testbench;
   logic                  clk, srst, ratio_slow, snoop_retry;
   logic                  copyback_req, go, copyback_gnt;
   logic                  tenure_done, early_retry, qual_retry;
   logic [1:0]            ack_wait;
   logic [4:0]            tt;
   arb_pkg::from_cpu_type cpu_in;
   arb_pkg::to_cpu_type   cpu_out;
   int                    num_errors, n_compared, ta_seen;

   addr_termination_data_bus_arb i_dut
   (
      .clk(clk), .srst(srst), .cpu_in(cpu_in), .cpu_out(cpu_out),
      .ratio_slow(ratio_slow), .ack_wait(ack_wait),
      .snoop_retry(snoop_retry), .copyback_req(copyback_req),
      .copyback_gnt(copyback_gnt), .tenure_done(tenure_done),
      .early_retry(early_retry), .qual_retry(qual_retry)
   );
   cpu_model i_cpu
   (
      .clk(clk), .srst(srst), .go(go), .tt_in(tt),
      .cpu_out(cpu_out), .cpu_in(cpu_in)
   );

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      if (cpu_out.transfer_acknowledge_n === 1'b0)
         ta_seen <= ta_seen + 1;
   end

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatched %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic tick(inout int i);
      @(posedge clk);
      i++;
      if (i > 60)
      begin
         num_errors++;
         $display("wrong value at %0t: wait ran out", $time);
         close_out();
      end
   endtask

   // Outcome as {done, early, qual}
   function automatic logic [2:0] exp_kind(input int tc, input int m);
      if (m == 0)
         return 3'h4;
      if (m == 1 && tc > 1)
         return 3'h2;
      return 3'h1;
   endfunction

   task automatic run(input logic [4:0] t, input logic [1:0] w,
                      input int m);
      int         tc;
      int         i;
      int         ta0;
      logic [2:0] kind;
      tc           = (ratio_slow ? 2 : 1) + int'(w);
      ta0          = ta_seen;
      i            = 0;
      ack_wait     <= w;
      tt           <= t;
      copyback_req <= 1'($urandom);
      go           <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
      while (cpu_in.transfer_start_n !== 1'b0)
         tick(i);
      if (m == 1 || (m == 2 && tc == 1))
         snoop_retry <= 1'b1;
      repeat (tc - 1) @(posedge clk);
      if (m == 2 && tc > 1)
         snoop_retry <= 1'b1;
      @(posedge clk);
      snoop_retry <= 1'b0;
      check(8'(cpu_out.address_acknowledge_o), 8'h00);
      kind = 3'h0;
      while (kind === 3'h0)
      begin
         tick(i);
         kind = {tenure_done, early_retry, qual_retry};
      end
      check(8'(kind), 8'(exp_kind(tc, m)));
      if (kind === 3'h1)
      begin
         @(posedge clk);
         check(8'(copyback_gnt), 8'(copyback_req));
      end
      if (kind !== 3'h4)
      begin
         tick(i);
         while (tenure_done !== 1'b1)
            tick(i);
      end
      repeat (20) @(posedge clk);
      check(8'(ta_seen - ta0), ((t & `ADDR_ONLY_MASK) == `ADDR_ONLY_VALUE)
            ? 8'h00 : 8'h04);
   endtask

   initial
   begin
      num_errors   = 0;
      n_compared   = 0;
      ta_seen      = 0;
      srst         = 1'b1;
      ratio_slow   = 1'b0;
      ack_wait     = 2'h0;
      snoop_retry  = 1'b0;
      copyback_req = 1'b0;
      go           = 1'b0;
      tt           = 5'h00;
      void'($urandom(32'he704));
      for (int r = 0; r < 2; r++)
      begin
         ratio_slow <= 1'(r);
         srst       <= 1'b1;
         repeat (12) @(posedge clk);
         check(8'(cpu_out), 8'hd7);
         srst <= 1'b0;
         repeat (2) @(posedge clk);
         run(5'h08, 2'h0, 1);
         run(5'h00, 2'h3, 0);
         for (int k = 0; k < 12; k++)
            run(5'($urandom), 2'(k), k / 4);
         for (int k = 0; k < 8; k++)
            run(5'($urandom), 2'($urandom), int'($urandom % 3));
      end
      close_out();
   end
endmodule
